// File: src/line_timing_map.svh
// register offsets, field positions and timing counts of the line timing block
`ifndef LINE_TIMING_MAP_SVH
`define LINE_TIMING_MAP_SVH
`define OFS_STD_CTRL 8'h0F
`define OFS_TIP 8'h10
`define OFS_GAP 8'h11
`define OFS_BURST 8'h12
`define OFS_CBP 8'h13
`define OFS_XBP 8'h14
`define OFS_ACT 8'h15
`define OFS_ACT_START 8'h16
`define OFS_ACT_END 8'h17
`define OFS_UPPER 8'h18
`define OFS_FP 8'h19
`define OFS_EQ_LOW 8'h1A
`define OFS_EQ_HIGH 8'h1B
`define OFS_VS_LOW 8'h1C
`define OFS_VS_HIGH 8'h1D
`define OFS_BAR 8'h1E
`define OFS_STATUS 8'h1F
`define BIT_MIRROR 7
`define BIT_LONG_FRAME 6
`define BIT_PAL 5
`define BIT_PEDESTAL 4
`define LINES_LONG 10'h271
`define LINES_SHORT 10'h20D
`define PULSE_ADD_256 10'h100
`define FIELD_DELAY 4'hC
`define KIND_DELAY 4'h5
`define STD_RESET 8'h00
`define LEN_RESET 8'h00
`define KIND_NORMAL 5'h00
`define KIND_VSYNC 5'h01
`define KIND_EQUAL 5'h02
`define VSYNC_LINES 10'h006
`define EQUAL_LINES 10'h009
`endif

// File: src/line_timing_pkg.sv
// types shared by the line timing block
package line_timing_pkg;
  typedef struct packed {
    logic mirrored_enable_flag;
    logic long_frame_select;
    logic phase_alternate_select;
    logic pedestal_enable;
    logic [1:0] luma_gain_code;
    logic [1:0] chroma_gain_code;
  } std_ctrl_t;
  typedef struct packed {
    logic [1:0] luma_gain_code;
    logic [1:0] chroma_gain_code;
    logic pedestal_enable;
    logic phase_alternate_select;
    logic phase_flip;
  } video_mode_t;
  typedef enum logic [7:0] {
    ST_TIP = 8'h01,
    ST_GAP = 8'h02,
    ST_BURST = 8'h04,
    ST_CBP = 8'h08,
    ST_ACTIVE = 8'h10,
    ST_FP = 8'h20,
    ST_PULSE_LOW = 8'h40,
    ST_PULSE_HIGH = 8'h80
  } seg_t;
endpackage

// File: src/video_standard_line_timing.sv
// line and frame timing generator with standard control registers
//
// Functional notes
// - long frame select high gives 625 lines, low gives 525 lines
// - phase alternate select high gives PAL line alternation, else NTSC
// - pedestal enable adds the 7.5 IRE pedestal to output video
// - luma gain code bits 3-2 select luminance gain standard
// - chroma gain code bits 1-0 select chrominance gain standard
// - control bit 7 mirrors the external mirror flag input, writes ignored
// - sync tip lasts the programmed 0 to 255 pixel clocks
// - breezeway and burst each last their own programmed count
// - colour back porch lasts its programmed 0 to 255 count
// - extended back porch is ten bits, upper bits in shared bits 7-6
// - active video length is ten bits, upper bits in shared bits 5-4
// - starting half-line active length uses shared bits 3-2
// - ending half-line active length uses shared bits 1-0
// - front porch lasts its programmed 0 to 255 count
// - equalization low portion lasts its programmed count
// - equalization high portion lasts programmed value plus 256
// - vertical sync low portion lasts programmed value plus 256
// - vertical sync high portion lasts its programmed count
// - each colour bar is as wide as its programmed count
// - field id in status bits 7-5 refreshed 12 clocks after sync edge
// - line kind id in status bits 4-0 refreshed 5 clocks after sync edge
`timescale 1ns/1ps
`include "line_timing_map.svh"
module video_standard_line_timing #(
  parameter int LEN_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic ext_mirror_flag_i,
  input wire logic color_bar_test_i,
  output logic [7:0] reg_rdata_o,
  output logic combined_sync_pin_b_o,
  output logic burst_gate_o,
  output logic active_video_o,
  output logic bar_step_o,
  output line_timing_pkg::video_mode_t video_mode_o
);
  import line_timing_pkg::*;

  initial
  begin
    if (LEN_W != 10)
      $error("LEN_W must be 10");
  end

  // ==========================================================
  // registers
  std_ctrl_t std_ctrl;
  logic [7:0] tip_len, gap_len, burst_len, cbp_len, xbp_low, act_low;
  logic [7:0] act_start_low, act_end_low, upper_bits, fp_len;
  logic [7:0] eq_low_len, eq_high_len, vs_low_len, vs_high_len, bar_len;
  logic [2:0] field_id;
  logic [4:0] line_kind_id;

  wire wr_en = ce_i && reg_wr_i;
  // writes; bit 7 of the control register is not stored
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      std_ctrl <= `STD_RESET;
      {tip_len, gap_len, burst_len, cbp_len} <= {4{`LEN_RESET}};
      {xbp_low, act_low, act_start_low, act_end_low} <= {4{`LEN_RESET}};
      {upper_bits, fp_len, eq_low_len, eq_high_len} <= {4{`LEN_RESET}};
      {vs_low_len, vs_high_len, bar_len} <= {3{`LEN_RESET}};
    end
    else if (wr_en)
    begin
      std_ctrl.mirrored_enable_flag <= ext_mirror_flag_i;
      unique case (reg_addr_i)
        `OFS_STD_CTRL: std_ctrl[6:0] <= reg_wdata_i[6:0];
        `OFS_TIP: tip_len <= reg_wdata_i;
        `OFS_GAP: gap_len <= reg_wdata_i;
        `OFS_BURST: burst_len <= reg_wdata_i;
        `OFS_CBP: cbp_len <= reg_wdata_i;
        `OFS_XBP: xbp_low <= reg_wdata_i;
        `OFS_ACT: act_low <= reg_wdata_i;
        `OFS_ACT_START: act_start_low <= reg_wdata_i;
        `OFS_ACT_END: act_end_low <= reg_wdata_i;
        `OFS_UPPER: upper_bits <= reg_wdata_i;
        `OFS_FP: fp_len <= reg_wdata_i;
        `OFS_EQ_LOW: eq_low_len <= reg_wdata_i;
        `OFS_EQ_HIGH: eq_high_len <= reg_wdata_i;
        `OFS_VS_LOW: vs_low_len <= reg_wdata_i;
        `OFS_VS_HIGH: vs_high_len <= reg_wdata_i;
        `OFS_BAR: bar_len <= reg_wdata_i;
        default: ;
      endcase
    end
    else if (ce_i)
      std_ctrl.mirrored_enable_flag <= ext_mirror_flag_i;
  end

  // ten-bit lengths built from low byte and shared upper bits
  wire [9:0] xbp_len = {upper_bits[7:6], xbp_low};
  wire [9:0] act_len = {upper_bits[5:4], act_low};
  wire [9:0] act_start_len = {upper_bits[3:2], act_start_low};
  wire [9:0] act_end_len = {upper_bits[1:0], act_end_low};
  wire [9:0] lines_per_frame = std_ctrl.long_frame_select ?
    `LINES_LONG : `LINES_SHORT;

  // read data mux
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr_i)
      `OFS_STD_CTRL: rd_mux = std_ctrl;
      `OFS_TIP: rd_mux = tip_len;
      `OFS_GAP: rd_mux = gap_len;
      `OFS_BURST: rd_mux = burst_len;
      `OFS_CBP: rd_mux = cbp_len;
      `OFS_XBP: rd_mux = xbp_low;
      `OFS_ACT: rd_mux = act_low;
      `OFS_ACT_START: rd_mux = act_start_low;
      `OFS_ACT_END: rd_mux = act_end_low;
      `OFS_UPPER: rd_mux = upper_bits;
      `OFS_FP: rd_mux = fp_len;
      `OFS_EQ_LOW: rd_mux = eq_low_len;
      `OFS_EQ_HIGH: rd_mux = eq_high_len;
      `OFS_VS_LOW: rd_mux = vs_low_len;
      `OFS_VS_HIGH: rd_mux = vs_high_len;
      `OFS_BAR: rd_mux = bar_len;
      `OFS_STATUS: rd_mux = {field_id, line_kind_id};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (ce_i && reg_rd_i)
      reg_rdata_o <= rd_mux;
  end

  // ==========================================================
  // segment sequencer
  seg_t seg, next_seg;
  logic [9:0] seg_cnt, next_cnt;
  logic [9:0] line_num;
  logic half_sel, phase_flip;
  logic [2:0] field_cnt;
  logic [7:0] bar_cnt;

  wire in_vsync = line_num < `VSYNC_LINES;
  wire in_equal = !in_vsync && line_num < `EQUAL_LINES;
  wire first_line = line_num == 10'h000;
  wire last_line = line_num == lines_per_frame - 10'h001;
  wire seg_done = seg_cnt == 10'h000;

  // segment length less one; zero length passes in one clock
  function automatic logic [9:0] load_len(input logic [9:0] len);
    load_len = (len == 10'h000) ? 10'h000 : len - 10'h001;
  endfunction

  // active video length chosen by half-line position
  wire [9:0] act_pick = first_line ? act_start_len :
    last_line ? act_end_len : act_len;
  wire [9:0] pulse_low = {2'b00, vs_low_len} + `PULSE_ADD_256;
  wire [9:0] pulse_high = {2'b00, eq_high_len} + `PULSE_ADD_256;

  // line boundary and the kind of the line that follows
  wire line_end = seg_done && (seg == ST_FP || seg == ST_PULSE_HIGH);
  wire [9:0] next_line = last_line ? 10'h000 : line_num + 10'h001;
  wire next_vs = next_line < `VSYNC_LINES;
  wire next_eq = !next_vs && next_line < `EQUAL_LINES;

  // next segment and its counter
  always_comb
  begin
    next_seg = seg;
    next_cnt = seg_cnt - 10'h001;
    if (seg_done)
    begin
      unique case (seg)
        ST_TIP:
        begin
          next_seg = ST_GAP;
          next_cnt = load_len({2'b00, gap_len});
        end
        ST_GAP:
        begin
          next_seg = ST_BURST;
          next_cnt = load_len({2'b00, burst_len});
        end
        ST_BURST:
        begin
          next_seg = ST_CBP;
          next_cnt = load_len({2'b00, cbp_len} + xbp_len);
        end
        ST_CBP:
        begin
          next_seg = ST_ACTIVE;
          next_cnt = load_len(act_pick);
        end
        ST_ACTIVE:
        begin
          next_seg = ST_FP;
          next_cnt = load_len({2'b00, fp_len});
        end
        ST_PULSE_LOW:
        begin
          next_seg = ST_PULSE_HIGH;
          next_cnt = in_vsync ? load_len({2'b00, vs_high_len}) :
            load_len(pulse_high);
        end
        default:
        begin
          next_seg = (next_vs || next_eq) ? ST_PULSE_LOW : ST_TIP;
          next_cnt = next_vs ? load_len(pulse_low) :
            next_eq ? load_len({2'b00, eq_low_len}) :
            load_len({2'b00, tip_len});
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      seg <= ST_FP;
      seg_cnt <= 10'h000;
      line_num <= 10'h000;
      half_sel <= 1'b0;
      phase_flip <= 1'b0;
      field_cnt <= 3'h0;
    end
    else if (ce_i)
    begin
      seg <= next_seg;
      seg_cnt <= next_cnt;
      if (line_end)
      begin
        line_num <= next_line;
        phase_flip <= std_ctrl.phase_alternate_select & ~phase_flip;
        if (last_line)
          field_cnt <= field_cnt + 3'h1;
      end
    end
  end

  // ==========================================================
  // sync edge delays for the status fields
  logic [3:0] since_edge;
  wire sync_edge = ce_i && seg_done &&
    (next_seg == ST_TIP || next_seg == ST_PULSE_LOW);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      since_edge <= `FIELD_DELAY;
      field_id <= 3'h0;
      line_kind_id <= `KIND_NORMAL;
    end
    else if (ce_i)
    begin
      if (sync_edge)
        since_edge <= 4'h0; // counts clocks after the pin edge
      else if (since_edge != `FIELD_DELAY)
        since_edge <= since_edge + 4'h1;
      if (since_edge == `KIND_DELAY - 4'h1 && !sync_edge)
        line_kind_id <= in_vsync ? `KIND_VSYNC :
          in_equal ? `KIND_EQUAL : `KIND_NORMAL;
      if (since_edge == `FIELD_DELAY - 4'h1 && !sync_edge)
        field_id <= field_cnt;
    end
  end

  // ==========================================================
  // output pins and colour bar stepping
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      combined_sync_pin_b_o <= 1'b1;
      burst_gate_o <= 1'b0;
      active_video_o <= 1'b0;
      bar_step_o <= 1'b0;
      bar_cnt <= 8'h00;
      video_mode_o <= '0;
    end
    else if (ce_i)
    begin
      combined_sync_pin_b_o <= !(next_seg == ST_TIP ||
        next_seg == ST_PULSE_LOW);
      burst_gate_o <= next_seg == ST_BURST && !in_vsync;
      active_video_o <= next_seg == ST_ACTIVE;
      bar_step_o <= 1'b0;
      if (next_seg != ST_ACTIVE || !color_bar_test_i)
        bar_cnt <= 8'h00;
      else if (bar_cnt + 8'h01 >= bar_len) // bar of bar_len clocks
      begin
        bar_cnt <= 8'h00;
        bar_step_o <= 1'b1;
      end
      else
        bar_cnt <= bar_cnt + 8'h01;
      video_mode_o.luma_gain_code <= std_ctrl.luma_gain_code;
      video_mode_o.chroma_gain_code <= std_ctrl.chroma_gain_code;
      video_mode_o.pedestal_enable <= std_ctrl.pedestal_enable;
      video_mode_o.phase_alternate_select <=
        std_ctrl.phase_alternate_select;
      video_mode_o.phase_flip <= phase_flip;
    end
  end

  // ==========================================================
  // checks
  // five running clocks after a sync edge, when the line kind is due
  sequence kind_wait;
    sync_edge ##1 ce_i [*5];
  endsequence

  a_long_frame: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    std_ctrl.long_frame_select |-> lines_per_frame == `LINES_LONG)
    else $error("long frame count wrong");
  a_mirror_ro: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i |=> std_ctrl.mirrored_enable_flag == $past(ext_mirror_flag_i))
    else $error("mirror bit not tracking");
  a_kind_delay: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    kind_wait |=> line_kind_id == (in_vsync ? `KIND_VSYNC :
      in_equal ? `KIND_EQUAL : `KIND_NORMAL))
    else $error("line kind not refreshed in time");
  a_field_wait: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    sync_edge |=> $stable(field_id))
    else $error("field id moved at the sync edge");
  a_tip_first: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    seg == ST_TIP && seg_done && ce_i |=> seg == ST_GAP)
    else $error("tip not followed by gap");
  a_sync_pin: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ce_i |=> combined_sync_pin_b_o ==
      !(seg == ST_TIP || seg == ST_PULSE_LOW))
    else $error("sync pin does not follow the segment");
  a_pulse_low: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    seg == ST_PULSE_LOW && in_vsync |->
      seg_cnt < `PULSE_ADD_256 + `PULSE_ADD_256)
    else $error("vsync low too long");
endmodule

// File: tb/host_port_model.sv
// host processor model driving the byte-wide control port
`timescale 1ns/1ps
module host_port_model (
  input wire logic mclk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic ce_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o
);
  // ========================================
  // idle bus
  initial
  begin
    ce_o = 1'b1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // released lines show the inverse of their last value, not a stale copy
  task automatic let_go();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    @(posedge mclk_i);
    #1;
  endtask
  // ========================================
  // transfers: entered just after an edge, held until the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge mclk_i);
    #1;
    let_go();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge mclk_i);
    #1;
    d = reg_rdata_i;
    let_go();
  endtask
  // clock enable low for eight edges with a write offered; nothing moves
  task automatic freeze(input logic [7:0] a, input logic [7:0] d);
    ce_o = 1'b0;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    repeat (8)
    begin
      @(posedge mclk_i);
      #1;
    end
    reg_wr_o = 1'b0;
    ce_o = 1'b1;
  endtask
endmodule

// File: tb/video_standard_line_timing_bench.sv
// self-checking bench for the line timing generator
`timescale 1ns/1ps
`include "line_timing_map.svh"
module video_standard_line_timing_bench;
  import line_timing_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ext_flag = 1'b0;
  logic bar_en = 1'b0;
  logic ce, wr, rd, sync_b, burst, act, bar;
  logic [7:0] addr, wdata, rdata;
  video_mode_t mode;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h96914E8F;
  logic [7:0] v [15];
  logic armed = 1'b0;
  logic seen_va = 1'b0;
  logic bar_ok = 1'b0;
  logic prv_s = 1'b1, prv_b = 1'b0, prv_a = 1'b0;
  logic [2:0] last_ev = 3'h0, ev;
  logic [15:0] since = 16'h0000, lo_w = 16'h0000, bcnt = 16'h0000;
  // ========================================
  // helpers
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed[7:0];
  endfunction
  // line kind expected from the width of a sync low pulse
  function automatic logic [15:0] kind_of(input logic [15:0] w);
    if (w == {8'h00, v[0]})
      return {11'h000, `KIND_NORMAL};
    if (w == {8'h00, v[10]})
      return {11'h000, `KIND_EQUAL};
    if (w == {8'h00, v[12]} + 16'h0100)
      return {11'h000, `KIND_VSYNC};
    return 16'hFFFF;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_sync(input logic val);
    int k;
    k = 0;
    while (sync_b !== val && k < 4000)
    begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k == 4000)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  // ========================================
  // instances
  host_port_model host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .ce_o(ce),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
  video_standard_line_timing dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ce_i(ce), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .ext_mirror_flag_i(ext_flag),
    .color_bar_test_i(bar_en), .reg_rdata_o(rdata),
    .combined_sync_pin_b_o(sync_b), .burst_gate_o(burst),
    .active_video_o(act), .bar_step_o(bar), .video_mode_o(mode));
  initial
    forever #2.5 mclk_i = ~mclk_i;
  // ========================================
  // segment monitor: cycles between edges of sync, burst and active
  always @(posedge mclk_i)
  begin
    ev = 3'h0;
    if (sync_b !== prv_s)
      ev = sync_b ? 3'h2 : 3'h1;
    else if (burst !== prv_b)
      ev = burst ? 3'h4 : 3'h3;
    else if (act !== prv_a)
      ev = act ? 3'h6 : 3'h5;
    if (ev != 3'h0)
    begin
      if ({last_ev, ev} == 6'o12)
        lo_w = since;
      if (armed)
        case ({last_ev, ev})
          6'o21: chk(since, lo_w > 16'h00FF ? {8'h00, v[13]} :
            {8'h00, v[11]} + 16'h0100);
          6'o24: chk(since, {8'h00, v[1]});
          6'o43: chk(since, {8'h00, v[2]});
          6'o36: chk(since, {v[8][7:6], v[4]} + v[3]);
          6'o65: chk(since == {v[8][5:4], v[5]} || since == v[6] ||
            since == v[7], 1'b1);
          6'o51: chk(since, {8'h00, v[9]});
          default: ;
        endcase
      if (armed && ev == 3'h5 && since == {v[8][5:4], v[5]})
        seen_va = 1'b1;
      last_ev = ev;
      since = 16'h0001;
    end
    else
      since++;
    if (bar === 1'b1)
    begin
      if (armed && bar_ok)
        chk(bcnt, {8'h00, v[14]});
      bcnt = 16'h0001;
      bar_ok = act;
    end
    else
      bcnt++;
    if (act !== 1'b1)
      bar_ok = 1'b0;
    prv_s = sync_b;
    prv_b = burst;
    prv_a = act;
  end
  // ========================================
  // main sequence
  initial
  begin
    logic [7:0] r, w;
    logic [15:0] k;
    logic [2:0] seen;
    logic pf;
    seen = 3'h0;
    repeat (8) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    bar_en = 1'b1;
    for (int i = 0; i < 15; i++)
      v[i] = rnd();
    v[0] = 8'h0C + v[0][4:0];
    v[1] = 8'h01 + v[1][3:0];
    v[2] = 8'h01 + v[2][3:0];
    v[3] = 8'h01 + v[3][3:0];
    v[4] = {3'h0, v[4][4:0]};
    v[8] = 8'h10;
    v[9] = 8'h01 + v[9][3:0];
    v[10] = 8'h2C + v[10][4:0];
    v[13] = 8'h01 + v[13][6:0];
    v[14] = 8'h14 + v[14][5:0];
    for (int i = 0; i < 15; i++)
      host.wr(`OFS_TIP + i[7:0], v[i]);
    for (int i = 0; i < 15; i++)
    begin
      host.rd(`OFS_TIP + i[7:0], r);
      chk(r, v[i]);
    end
    host.wr(8'h30, rnd());
    host.rd(8'h30, r);
    chk(r, 8'h00);
    for (int g = 0; g < 4; g++)
    begin
      r = rnd();
      ext_flag = r[0];
      w = {~r[0], 1'b0, r[5:4], g[1:0], ~g[1:0]};
      host.wr(`OFS_STD_CTRL, w);
      host.rd(`OFS_STD_CTRL, r);
      chk(r, {ext_flag, w[6:0]});
      chk(mode.luma_gain_code, g[1:0]);
      chk(mode.chroma_gain_code, w[1:0]);
      chk(mode.pedestal_enable, w[4]);
      chk(mode.phase_alternate_select, w[5]);
    end
    // clock enable low: pins and read data hold, the offered write is lost
    k = {5'h00, sync_b, burst, act, rdata};
    host.freeze(`OFS_BAR, ~v[14]);
    chk({5'h00, sync_b, burst, act, rdata}, k);
    host.rd(`OFS_BAR, r);
    chk(r, v[14]);
    wait_sync(1'b0);
    wait_sync(1'b1);
    wait_sync(1'b0);
    armed = 1'b1;
    pf = mode.phase_flip;
    for (int i = 0; i < 40; i++)
    begin
      wait_sync(1'b0);
      repeat (6) @(posedge mclk_i);
      #1;
      host.rd(`OFS_STATUS, r);
      wait_sync(1'b1);
      @(posedge mclk_i);
      #1;
      chk(mode.phase_flip, {15'h0000, w[5] & ~pf});
      pf = mode.phase_flip;
      k = kind_of(lo_w);
      chk({8'h00, r}, k);
      if (k[1:0] != 2'h3)
        seen[k[1:0]] = 1'b1;
    end
    chk({seen, seen_va}, 4'hF);
    close_out();
  end
endmodule
